// >>> rtl/dprs_buf.sv
/*
 * two-entry valid/ready buffer for trigger words.
 * assumes one clock, asynchronous active-low reset.
 */
`timescale 1ns/1ps
`include "dprs_params.svh"
module dprs_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `DPRS_BUF_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_q [DEPTH]; // storage
    logic [AW-1:0] wr_q; // write index
    logic [AW-1:0] rd_q; // read index
    logic [AW:0] cnt_q; // occupancy
    logic push; // word written this cycle
    logic pop; // word read this cycle

    // wrap an index at depth
    function automatic logic [AW-1:0] nxt(input logic [AW-1:0] i);
        nxt = (i == AW'(DEPTH - 1)) ? '0 : i + AW'(1);
    endfunction

    assign in_ready = (cnt_q != (AW + 1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= nxt(wr_q);
            end
            if (pop) begin
                rd_q <= nxt(rd_q);
            end
            cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule // dprs_buf

// >>> rtl/dprs_params.svh
/*
 * constants for the dma peripheral request selector: select codes,
 * request source count and buffer sizing.
 * assumes inclusion by bare name from any design file.
 */
`ifndef DPRS_PARAMS_SVH
`define DPRS_PARAMS_SVH

// select codes for the three-bit request select field
`define DPRS_SEL_TMR0 3'h0
`define DPRS_SEL_TMR1 3'h1
`define DPRS_SEL_TMR2 3'h2
`define DPRS_SEL_TMR3 3'h3
`define DPRS_SEL_SER0_RX 3'h4
`define DPRS_SEL_SER0_TX 3'h5
`define DPRS_SEL_SER1_RX 3'h6
`define DPRS_SEL_SER1_TX 3'h7
// number of request sources
`define DPRS_NUM_SRC 8
// buffer depth
`define DPRS_BUF_DEPTH 2

`endif

// >>> rtl/dprs_pkg.sv
/*
 * types for the dma peripheral request selector.
 * assumes dprs_params.svh is on the include path.
 */
package dprs_pkg;
    // which end of a transfer is pinned to a serial data register
    typedef enum logic [1:0] {
        DPRS_FIX_NONE = 2'b00, // any source, any destination
        DPRS_FIX_SRC = 2'b01,  // source pinned to a receive data register
        DPRS_FIX_DST = 2'b10   // destination pinned to a transmit data register
    } dprs_fix_e;
    // pinned serial data register
    typedef enum logic [2:0] {
        DPRS_REG_NONE = 3'b000,
        DPRS_REG_SER0_RX = 3'b001, // serial0_rx_data_reg
        DPRS_REG_SER0_TX = 3'b010, // serial0_tx_data_reg
        DPRS_REG_SER1_RX = 3'b011, // serial1_rx_data_reg
        DPRS_REG_SER1_TX = 3'b100  // serial1_tx_data_reg
    } dprs_reg_e;
    // channel request state
    typedef enum logic [0:0] {
        DPRS_IDLE = 1'b0,
        DPRS_BUSY = 1'b1
    } dprs_state_e;
endpackage

// >>> rtl/dprs_sel.sv
/*
 * request selector for one dma channel triggered by on-chip peripherals.
 * picks one of eight peripheral requests, pins the source or destination
 * for serial triggers, and withdraws the request when the transfer runs.
 * one trigger is outstanding at a time; a request that stays high
 * through a burst gives a single trigger.
 * assumes peripheral request lines are synchronous to clk, and the dma
 * channel sees pinned-register codes and bus mode with each trigger.
 */
// Operation
// - code 000: timer 0 compare A, any ends
// - code 001: timer 1 compare A, any ends
// - code 010: timer 2 compare A, any ends
// - code 011: timer 3 compare A, any ends
// - code 100: serial 0 rx, source rx register
// - code 110: serial 1 rx, source rx register
// - request cleared: first steal, last burst

`timescale 1ns/1ps
`include "dprs_params.svh"
module dprs_sel
    import dprs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration
    input wire logic req_sel_bit2,
    input wire logic req_sel_bit1,
    input wire logic req_sel_bit0,
    input wire logic burst_mode, // 1 burst, 0 cycle steal
    input wire logic chan_enable,
    // peripheral requests
    input wire logic timer0_cmpa_req,
    input wire logic timer1_cmpa_req,
    input wire logic timer2_cmpa_req,
    input wire logic timer3_cmpa_req,
    input wire logic serial0_rx_full_req,
    input wire logic serial0_tx_empty_req,
    input wire logic serial1_rx_full_req,
    input wire logic serial1_tx_empty_req,
    // transfer progress from the channel
    input wire logic xfer_done,  // one pulse per transfer
    input wire logic xfer_last,  // with xfer_done on the final transfer
    // trigger towards the channel
    output logic trig_valid,
    input wire logic trig_ready,
    output dprs_pkg::dprs_fix_e trig_fix,
    output dprs_pkg::dprs_reg_e trig_reg,
    output logic trig_burst,
    // request withdrawal towards the peripherals
    output logic [`DPRS_NUM_SRC-1:0] req_clear,
    output logic busy
);
    import dprs_pkg::*;

    // trigger word width: pinned end, pinned register, bus mode
    localparam int TW = 2 + 3 + 1; // fix, reg, burst

    // select decode
    logic [2:0] sel; // select field
    logic [`DPRS_NUM_SRC-1:0] reqs; // all request lines
    logic picked; // selected request level
    dprs_fix_e fix_d; // pinned end for the current code
    dprs_reg_e reg_d; // pinned register for the current code
    // request state
    dprs_state_e state_q; // idle, or waiting for withdrawal
    logic clear_gap; // withdrawal pulse to the selected source still stands
    // buffer interface
    logic in_valid; // trigger offered to the buffer
    logic in_ready; // buffer has room
    logic [TW-1:0] in_word; // word offered to the buffer
    logic [TW-1:0] out_word; // oldest buffered word
    logic out_valid; // buffer holds a word
    logic pop; // output stage takes the oldest word
    // output stage and withdrawal pulse
    logic trig_valid_q; // trigger word on offer to the channel
    logic [TW-1:0] trig_word_q; // trigger word held for the channel
    logic [`DPRS_NUM_SRC-1:0] clear_q; // one-cycle withdrawal pulse

    // withdrawal point: first transfer in cycle steal, last one in burst;
    // shared by the state update and the withdrawal pulse so they agree
    function automatic logic withdraw_due(input logic done, input logic last, input logic bm);
        withdraw_due = done && (!bm || last);
    endfunction

    // select field gathered from its three bits
    assign sel = {req_sel_bit2, req_sel_bit1, req_sel_bit0};
    // request lines packed by select code, timers low, serial high
    assign reqs = {serial1_tx_empty_req, serial1_rx_full_req,
                   serial0_tx_empty_req, serial0_rx_full_req,
                   timer3_cmpa_req, timer2_cmpa_req,
                   timer1_cmpa_req, timer0_cmpa_req};
    // only the chosen line is looked at
    assign picked = reqs[sel];

    // decode pinned end and register from the select code;
    // serial receive codes pin the source, transmit codes the destination
    always_comb begin
        // timer codes pin neither end
        fix_d = DPRS_FIX_NONE;
        reg_d = DPRS_REG_NONE;
        unique case (sel)
            `DPRS_SEL_TMR0, `DPRS_SEL_TMR1, `DPRS_SEL_TMR2, `DPRS_SEL_TMR3: begin
                fix_d = DPRS_FIX_NONE;
                reg_d = DPRS_REG_NONE;
            end
            `DPRS_SEL_SER0_RX: begin
                fix_d = DPRS_FIX_SRC;
                reg_d = DPRS_REG_SER0_RX;
            end
            `DPRS_SEL_SER0_TX: begin
                fix_d = DPRS_FIX_DST;
                reg_d = DPRS_REG_SER0_TX;
            end
            `DPRS_SEL_SER1_RX: begin
                fix_d = DPRS_FIX_SRC;
                reg_d = DPRS_REG_SER1_RX;
            end
            `DPRS_SEL_SER1_TX: begin
                fix_d = DPRS_FIX_DST;
                reg_d = DPRS_REG_SER1_TX;
            end
        endcase
    end

    // one trigger per request until it is withdrawn; the peripheral drops
    // its flag only one cycle after seeing the withdrawal pulse, so the
    // stale level is masked while the pulse stands, which would otherwise
    // start a second, unwanted trigger straight after the withdrawal
    assign clear_gap = clear_q[sel];
    assign in_valid = chan_enable && picked && (state_q == DPRS_IDLE) && !clear_gap;
    assign in_word = {fix_d, reg_d, burst_mode};

    // request state: busy from trigger until withdrawal; while it stands
    // the selected request is not looked at again, so a level that stays
    // high through a burst yields exactly one trigger word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= DPRS_IDLE;
        end else begin
            unique case (state_q)
                DPRS_IDLE: begin
                    // trigger taken once the buffer has room
                    if (in_valid && in_ready) begin
                        state_q <= DPRS_BUSY;
                    end
                end
                DPRS_BUSY: begin
                    // steal clears on first, burst on last transfer
                    if (withdraw_due(xfer_done, xfer_last, burst_mode)) begin
                        state_q <= DPRS_IDLE;
                    end
                end
            endcase
        end
    end

    // two-entry buffer so a stalled channel loses no trigger word
    dprs_buf #(
        .WIDTH(TW),
        .DEPTH(`DPRS_BUF_DEPTH)
    ) dprs_buf_i (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data(in_word),
        .out_valid(out_valid),
        .out_ready(pop),
        .out_data(out_word)
    );

    // output stage loads when empty or when current word is taken;
    // it refills in the same cycle that the channel takes the current word
    assign pop = out_valid && (!trig_valid_q || trig_ready);

    // registered trigger outputs, so every trigger output comes from a flop;
    // the word stands unchanged while the channel holds trig_ready low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_valid_q <= 1'b0;
            trig_word_q <= '0;
        end else begin
            if (!trig_valid_q || trig_ready) begin
                // load the next word or let the stage empty
                trig_valid_q <= out_valid;
                if (out_valid) begin
                    trig_word_q <= out_word;
                end
            end
        end
    end

    // withdrawal pulse to the selected peripheral
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clear_q <= '0;
        end else begin
            clear_q <= '0; // no pulse unless a withdrawal is due
            // burst_mode is read at the withdrawal, not at the trigger
            if (state_q == DPRS_BUSY && withdraw_due(xfer_done, xfer_last, burst_mode)) begin
                // only the selected source is withdrawn
                clear_q[sel] <= 1'b1;
            end
        end
    end

    // outputs taken straight from their registers;
    // trigger word fields are sliced from the output register
    assign trig_valid = trig_valid_q;
    assign trig_fix = dprs_fix_e'(trig_word_q[TW-1 -: 2]);
    assign trig_reg = dprs_reg_e'(trig_word_q[3:1]);
    assign trig_burst = trig_word_q[0];
    assign req_clear = clear_q;
    // busy is the state flop itself, its busy code being 1
    assign busy = logic'(state_q);
endmodule // dprs_sel

// >>> verif/dprs_periph_model.sv
/* peripheral request flags: set by raise, withdrawn by req_clear.
   assumes the selector clock and reset. */
`timescale 1ns/1ps
module dprs_periph_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // events and withdrawal
    input wire logic [7:0] raise,
    input wire logic [7:0] req_clear,
    // request levels
    output logic [7:0] req_q
);
    // each flag is an enabled interrupt output doubling as request
    // cpu assumed masked, so only the channel withdraws it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_q <= 8'h00;
        end else begin
            req_q <= (req_q & ~req_clear) | raise;
        end
    end
endmodule // dprs_periph_model

// >>> verif/dprs_sel_properties.sv
/* checker for the request selector ports.
   assumes it is bound onto dprs_sel with one clock. */
`timescale 1ns/1ps
module dprs_sel_properties
    import dprs_pkg::*;
(
    // all selector ports
    input wire logic clk, rst_n, req_sel_bit2, req_sel_bit1, req_sel_bit0,
    input wire logic burst_mode, chan_enable, xfer_done, xfer_last,
    input wire logic timer0_cmpa_req, timer1_cmpa_req, timer2_cmpa_req,
    input wire logic timer3_cmpa_req, serial0_rx_full_req, serial0_tx_empty_req,
    input wire logic serial1_rx_full_req, serial1_tx_empty_req,
    input wire logic trig_valid, trig_ready, trig_burst, busy,
    input dprs_pkg::dprs_fix_e trig_fix,
    input dprs_pkg::dprs_reg_e trig_reg,
    input wire logic [7:0] req_clear
);
    wire logic [2:0] sel = {req_sel_bit2, req_sel_bit1, req_sel_bit0}; // select code
    wire logic [7:0] reqs = {serial1_tx_empty_req, serial1_rx_full_req, serial0_tx_empty_req,
        serial0_rx_full_req, timer3_cmpa_req, timer2_cmpa_req, timer1_cmpa_req, timer0_cmpa_req};
    wire logic take = chan_enable && reqs[sel] && !busy && !req_clear[sel]; // request taken
    wire logic drop = busy && xfer_done && (!burst_mode || xfer_last); // withdrawal due
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    take_busy_a: assert property (take |=> busy) else $error("busy not raised");
    ignore_other_a: assert property (!busy && !take |=> !busy)
        else $error("busy without selected request");
    word_time_a: assert property (take |-> ##2 (trig_valid && trig_burst == $past(burst_mode, 2)))
        else $error("trigger word late or wrong mode");
    timer_word_a: assert property (trig_valid && !sel[2] |->
        trig_fix == DPRS_FIX_NONE && trig_reg == DPRS_REG_NONE) else $error("timer word");
    ser0_rx_a: assert property (trig_valid && sel == 3'h4 |->
        trig_fix == DPRS_FIX_SRC && trig_reg == DPRS_REG_SER0_RX) else $error("rx0 word");
    ser0_tx_a: assert property (trig_valid && sel == 3'h5 |->
        trig_fix == DPRS_FIX_DST && trig_reg == DPRS_REG_SER0_TX) else $error("tx0 word");
    ser1_rx_a: assert property (trig_valid && sel == 3'h6 |->
        trig_fix == DPRS_FIX_SRC && trig_reg == DPRS_REG_SER1_RX) else $error("rx1 word");
    ser1_tx_a: assert property (trig_valid && sel == 3'h7 |->
        trig_fix == DPRS_FIX_DST && trig_reg == DPRS_REG_SER1_TX) else $error("tx1 word");
    clear_pulse_a: assert property (drop |=> !busy && req_clear == (8'h01 << $past(sel)))
        else $error("withdrawal missing");
    burst_hold_a: assert property (busy && xfer_done && burst_mode && !xfer_last |=> busy)
        else $error("burst withdrawn early");
    quiet_clear_a: assert property (!drop |=> req_clear == 8'h00)
        else $error("stray withdrawal");
    clear_gap_a: assert property (req_clear != 8'h00 |=> !busy)
        else $error("retrigger on withdrawn request");
    no_enable_a: assert property (!chan_enable && !busy |=> !busy)
        else $error("trigger while channel disabled");
endmodule // dprs_sel_properties
bind dprs_sel dprs_sel_properties dprs_sel_properties_i (.*);

// >>> verif/dprs_sel_tb_top.sv
/* random and corner tests of the request selector.
   assumes dprs_pkg and dprs_params.svh are compiled. */
`timescale 1ns/1ps
module dprs_sel_tb_top;
    import dprs_pkg::*;
    logic clk = 0, rst_n = 0, req_sel_bit2 = 0, req_sel_bit1 = 0, req_sel_bit0 = 0;
    logic burst_mode = 0, chan_enable = 1, xfer_done = 0, xfer_last = 0, trig_ready = 0;
    logic trig_valid, trig_burst, busy;
    logic [7:0] raise = 8'h00, req_clear, req_q;
    dprs_fix_e trig_fix;
    dprs_reg_e trig_reg;
    int err_total = 0, checks_done = 0, seed = 81275, r, c;
    bit hung = 0; // a trigger never came
    always #2 clk = ~clk; // 250 MHz
    dprs_periph_model dprs_periph_model_i (.clk, .rst_n, .raise, .req_clear, .req_q);
    dprs_sel dprs_sel_i (.*, .timer0_cmpa_req(req_q[0]), .timer1_cmpa_req(req_q[1]),
        .timer2_cmpa_req(req_q[2]), .timer3_cmpa_req(req_q[3]),
        .serial0_rx_full_req(req_q[4]), .serial0_tx_empty_req(req_q[5]),
        .serial1_rx_full_req(req_q[6]), .serial1_tx_empty_req(req_q[7]));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // expected pinned end and register per select code
    function automatic logic [4:0] exp_word(input logic [2:0] k);
        case (k)
            3'h4: return {DPRS_FIX_SRC, DPRS_REG_SER0_RX};
            3'h5: return {DPRS_FIX_DST, DPRS_REG_SER0_TX};
            3'h6: return {DPRS_FIX_SRC, DPRS_REG_SER1_RX};
            3'h7: return {DPRS_FIX_DST, DPRS_REG_SER1_TX};
            default: return 5'h00; // timers pin nothing
        endcase
    endfunction
    // one trigger: noise on sources other than the previously selected code, then the selected one
    task automatic run_one(input logic [2:0] k, input logic bm, input int n, input int st);
        int i;
        logic fin;
        raise = 8'($random(seed)) & ~(8'h01 << {req_sel_bit2, req_sel_bit1, req_sel_bit0});
        @(negedge clk);
        raise = 8'h00;
        repeat (3) @(negedge clk);
        check(busy, 0);
        {req_sel_bit2, req_sel_bit1, req_sel_bit0} = k;
        burst_mode = bm;
        chan_enable = 0;
        raise = 8'h01 << k;
        @(negedge clk);
        raise = 8'h00;
        repeat (2) @(negedge clk);
        check(busy, 0);
        chan_enable = 1;
        for (i = 0; i < 20 && trig_valid !== 1'b1; i++) @(negedge clk);
        if (trig_valid !== 1'b1) begin
            err_total++;
            $display("unexpected at %0t: no trigger", $time);
            hung = 1;
            return;
        end
        check({3'h0, trig_fix, trig_reg}, {3'h0, exp_word(k)});
        check(trig_burst, bm);
        repeat (st) @(negedge clk);
        check(trig_valid, 1);
        trig_ready = 1;
        @(negedge clk);
        trig_ready = 0;
        fin = 0;
        for (i = 0; i < n && !fin; i++) begin
            @(negedge clk);
            xfer_done = 1;
            xfer_last = (i == n - 1);
            @(negedge clk);
            xfer_done = 0;
            xfer_last = 0;
            fin = !bm || i == n - 1;
            check(busy, !fin);
            check(req_clear, fin ? 8'h01 << k : 8'h00);
        end
        $display("test code %0d burst %0d done", k, bm);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst_n = 1;
        for (c = 0; c < 8 && !hung; c++) run_one(c[2:0], c[0], 3, c % 3);
        repeat (16) begin
            r = $random(seed);
            if (!hung) run_one(r[2:0], r[3], 1 + r[5:4], r[7:6]);
        end
        close_out();
    end
endmodule // dprs_sel_tb_top
